// File: hdl/image_trigger_gate.sv
/*
  Image trigger gate: starts series of profiles from an external image trigger,
  paces profiles inside a series, and exposes control and status over APB.
  Assumes image_trigger and encoder_pulse are asynchronous single-ended levels
  and an APB master that holds each request until pready.
*/
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/10ps
`include "image_trigger_gate_defs.svh"

// Summary of operation
// - With gating off, series follow one another without looking at the trigger.
// - With gating on, a started series that is not stopped runs exactly the set number of profiles, or one profile if that number is zero.
// - Profiles inside a series are paced by the free-running timer or the encoder.
// - In edge start, a series begins only on a rising trigger edge.
// - In edge start, rising edges during an unfinished series are ignored.
// - In edge start, after a series the gate idles until a new rising edge.
// - In level start, a new series begins whenever the trigger is high.
// - In level start, the first series after starting needs a rising edge too.
// - Configuration is locked while acquisition runs.
// - In encoder pacing, pulses are counted up to the set count, then a trigger and a clear.
module image_trigger_gate #(
  parameter int LEN_W = 16,
  parameter int PERIOD_W = 32,
  parameter int PULSE_W = 16,
  parameter logic [31:0] FREE_PERIOD_RST = 32'(`ITG_FREE_PERIOD_CYC)
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic image_trigger,
  input wire logic encoder_pulse,
  output logic profile_trigger,
  output logic series_active,
  output logic series_done
);

  generate
    if (LEN_W < 1 || LEN_W > 16 || PERIOD_W < 2 || PERIOD_W > 32) begin : g_bad
      $error("image_trigger_gate parameter out of range");
    end
    if (PULSE_W < 1 || PULSE_W > 16) begin : g_bad_pulse
      $error("image_trigger_gate pulse width out of range");
    end
  endgenerate

  // configuration and control registers
  logic run_r;
  logic gate_en_r;
  logic edge_start_mode_r;
  logic level_start_mode_r;
  image_trigger_gate_pkg::pace_src_e pace_src_r;
  logic [LEN_W-1:0] series_len_r;
  logic [PERIOD_W-1:0] free_period_r;
  logic [PULSE_W-1:0] pulses_r;
  logic refused_r;
  logic [31:0] series_cnt_r;

  // sequencing state
  image_trigger_gate_pkg::gate_state_e state_r;
  image_trigger_gate_pkg::gate_state_e state_nxt;
  logic first_r;
  logic [LEN_W-1:0] prof_cnt_r;

  // bus pipeline
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;

  // synchronised inputs
  logic [1:0] sync_level;
  logic [1:0] sync_rise;
  logic trig_level;
  logic trig_rise;
  logic enc_rise;
  logic pace_tick;

  trigger_sync #(
    .WIDTH(2)
  ) u_sync (
    .clock(clock),
    .resetn(resetn),
    .din({encoder_pulse, image_trigger}),
    .level(sync_level),
    .rise(sync_rise)
  );

  assign trig_level = sync_level[0];
  assign trig_rise = sync_rise[0];
  assign enc_rise = sync_rise[1];

  wire in_series = (state_r == image_trigger_gate_pkg::st_series);

  profile_pacer #(
    .PERIOD_W(PERIOD_W),
    .PULSE_W(PULSE_W)
  ) u_pacer (
    .clock(clock),
    .resetn(resetn),
    .enable(in_series),
    .src(pace_src_r),
    .period(free_period_r),
    .pulses(pulses_r),
    .enc_rise(enc_rise),
    .tick(pace_tick)
  );

  // address decode; the write commits only at the edge where pready is seen
  wire access = psel && penable;
  wire commit = access && pready_r;
  wire wr_commit = commit && pwrite;
  wire sel_ctrl = (paddr == `ITG_CTRL_OFS);
  wire sel_len = (paddr == `ITG_SERIES_LEN_OFS);
  wire sel_period = (paddr == `ITG_FREE_PERIOD_OFS);
  wire sel_pulses = (paddr == `ITG_PULSES_OFS);
  wire sel_status = (paddr == `ITG_STATUS_OFS);
  wire sel_scnt = (paddr == `ITG_SERIES_CNT_OFS);
  wire mapped = sel_ctrl || sel_len || sel_period || sel_pulses || sel_status || sel_scnt;

  // parameters are frozen while the gate is not stopped
  wire cfg_open = (state_r == image_trigger_gate_pkg::st_stop) && !run_r;
  wire wr_ctrl = wr_commit && sel_ctrl;
  wire wr_cfg_ctrl = wr_ctrl && cfg_open;
  wire wr_len = wr_commit && sel_len && cfg_open;
  wire wr_period = wr_commit && sel_period && cfg_open;
  wire wr_pulses = wr_commit && sel_pulses && cfg_open;
  wire cfg_touch = wr_commit && (sel_len || sel_period || sel_pulses);
  wire ctrl_changes = wr_ctrl && ((pwdata[`ITG_CTRL_GATE_BIT] != gate_en_r) ||
    (pwdata[`ITG_CTRL_LEVEL_BIT] != level_start_mode_r) ||
    (pwdata[`ITG_CTRL_ENC_BIT] != pace_src_r));
  wire refuse_evt = !cfg_open && (cfg_touch || ctrl_changes);
  wire refuse_clr = wr_commit && sel_status && pwdata[`ITG_STAT_REFUSE_BIT];

  // series length of zero is served as one profile
  wire [LEN_W-1:0] len_last = (series_len_r == '0) ? '0 : series_len_r - 1'b1;
  wire last_profile = in_series && pace_tick && (prof_cnt_r >= len_last);

  // start decision while waiting
  wire level_go = first_r ? (trig_rise && trig_level) : trig_level;
  wire start_go = !gate_en_r || (edge_start_mode_r ? trig_rise : level_go);
  // restart straight from the end of a series
  wire restart = !gate_en_r || (level_start_mode_r && trig_level);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      image_trigger_gate_pkg::st_stop: begin
        if (run_r) begin
          state_nxt = image_trigger_gate_pkg::st_wait;
        end
      end
      image_trigger_gate_pkg::st_wait: begin
        if (!run_r) begin
          state_nxt = image_trigger_gate_pkg::st_stop;
        end else if (start_go) begin
          state_nxt = image_trigger_gate_pkg::st_series;
        end
      end
      image_trigger_gate_pkg::st_series: begin
        // stopping aborts a partial series; edges here are not looked at
        if (!run_r) begin
          state_nxt = image_trigger_gate_pkg::st_stop;
        end else if (last_profile) begin
          state_nxt = restart ? image_trigger_gate_pkg::st_series
                              : image_trigger_gate_pkg::st_wait;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_r <= image_trigger_gate_pkg::st_stop;
    end else begin
      state_r <= state_nxt;
    end
  end

  // first series after a start needs an edge even in level mode
  always_ff @(posedge clock) begin
    if (!resetn) begin
      first_r <= 1'b1;
    end else if (state_r == image_trigger_gate_pkg::st_stop) begin
      first_r <= 1'b1;
    end else if (state_nxt == image_trigger_gate_pkg::st_series) begin
      first_r <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      prof_cnt_r <= '0;
    end else if (!in_series || last_profile) begin
      prof_cnt_r <= '0;
    end else if (pace_tick) begin
      prof_cnt_r <= prof_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      series_cnt_r <= '0;
    end else if (last_profile) begin
      series_cnt_r <= series_cnt_r + 32'h0000_0001;
    end
  end

  // run bit is always writable so software can stop acquisition
  always_ff @(posedge clock) begin
    if (!resetn) begin
      run_r <= 1'b0;
    end else if (wr_ctrl) begin
      run_r <= pwdata[`ITG_CTRL_RUN_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      gate_en_r <= 1'b0;
      level_start_mode_r <= 1'b0;
      pace_src_r <= image_trigger_gate_pkg::pace_free;
    end else if (wr_cfg_ctrl) begin
      gate_en_r <= pwdata[`ITG_CTRL_GATE_BIT];
      level_start_mode_r <= pwdata[`ITG_CTRL_LEVEL_BIT];
      pace_src_r <= image_trigger_gate_pkg::pace_src_e'(pwdata[`ITG_CTRL_ENC_BIT]);
    end
  end

  assign edge_start_mode_r = !level_start_mode_r;

  // software is expected to keep the length at 100 or more to spare the host
  always_ff @(posedge clock) begin
    if (!resetn) begin
      series_len_r <= LEN_W'(`ITG_SERIES_LEN_RST);
    end else if (wr_len) begin
      series_len_r <= pwdata[LEN_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      free_period_r <= FREE_PERIOD_RST[PERIOD_W-1:0];
    end else if (wr_period) begin
      free_period_r <= pwdata[PERIOD_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      pulses_r <= PULSE_W'(`ITG_PULSES_RST);
    end else if (wr_pulses) begin
      pulses_r <= pwdata[PULSE_W-1:0];
    end
  end

  // sticky refusal flag; a new refusal wins over a clear in the same cycle
  always_ff @(posedge clock) begin
    if (!resetn) begin
      refused_r <= 1'b0;
    end else if (refuse_evt) begin
      refused_r <= 1'b1;
    end else if (refuse_clr) begin
      refused_r <= 1'b0;
    end
  end

  // read data mux
  logic [31:0] ctrl_rd;
  logic [31:0] status_rd;
  logic [31:0] rd_mux;

  always_comb begin
    ctrl_rd = '0;
    ctrl_rd[`ITG_CTRL_RUN_BIT] = run_r;
    ctrl_rd[`ITG_CTRL_GATE_BIT] = gate_en_r;
    ctrl_rd[`ITG_CTRL_LEVEL_BIT] = level_start_mode_r;
    ctrl_rd[`ITG_CTRL_ENC_BIT] = (pace_src_r == image_trigger_gate_pkg::pace_encoder);
    status_rd = '0;
    status_rd[`ITG_STAT_RUN_BIT] = (state_r != image_trigger_gate_pkg::st_stop);
    status_rd[`ITG_STAT_SERIES_BIT] = in_series;
    status_rd[`ITG_STAT_TRIG_BIT] = trig_level;
    status_rd[`ITG_STAT_REFUSE_BIT] = refused_r;
    status_rd[`ITG_STAT_CNT_LSB +: LEN_W] = prof_cnt_r;
  end

  assign rd_mux = sel_ctrl ? ctrl_rd :
                  sel_len ? 32'(series_len_r) :
                  sel_period ? 32'(free_period_r) :
                  sel_pulses ? 32'(pulses_r) :
                  sel_status ? status_rd :
                  sel_scnt ? series_cnt_r : 32'h0000_0000;

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge clock) begin
    if (!resetn) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= access && !pready_r;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else begin
      pslverr_r <= access && !pready_r && !mapped;
      prdata_r <= (access && !pready_r && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // outputs registered to keep them glitch free at the pins
  logic profile_trigger_r;
  logic series_active_r;
  logic series_done_r;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      profile_trigger_r <= 1'b0;
      series_active_r <= 1'b0;
      series_done_r <= 1'b0;
    end else begin
      profile_trigger_r <= in_series && pace_tick;
      series_active_r <= (state_nxt == image_trigger_gate_pkg::st_series);
      series_done_r <= last_profile;
    end
  end

  assign profile_trigger = profile_trigger_r;
  assign series_active = series_active_r;
  assign series_done = series_done_r;

endmodule : image_trigger_gate

// File: hdl/profile_pacer.sv
/*
  Profile pacing: a free-running interval timer or an encoder pulse counter.
  Emits a one-cycle tick per profile while enabled; state clears when disabled.
*/
`timescale 1ns/10ps
module profile_pacer #(
  parameter int PERIOD_W = 32,
  parameter int PULSE_W = 16
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic enable,
  input wire image_trigger_gate_pkg::pace_src_e src,
  input wire logic [PERIOD_W-1:0] period,
  input wire logic [PULSE_W-1:0] pulses,
  input wire logic enc_rise,
  output logic tick
);

  logic [PERIOD_W-1:0] time_r;
  logic [PULSE_W-1:0] enc_r;
  logic [PERIOD_W-1:0] period_last;
  logic [PULSE_W-1:0] pulses_last;
  logic time_hit;
  logic enc_hit;
  logic is_enc;

  generate
    if (PERIOD_W < 2 || PULSE_W < 1) begin : g_bad
      $error("profile_pacer widths too small");
    end
  endgenerate

  // a zero setting behaves as one, so the pacer can never stall
  assign period_last = (period == '0) ? '0 : period - 1'b1;
  assign pulses_last = (pulses == '0) ? '0 : pulses - 1'b1;
  assign is_enc = (src == image_trigger_gate_pkg::pace_encoder);
  assign time_hit = !is_enc && (time_r >= period_last);
  assign enc_hit = is_enc && enc_rise && (enc_r >= pulses_last);

  always_ff @(posedge clock) begin
    if (!resetn || !enable) begin
      time_r <= '0;
    end else if (time_hit) begin
      time_r <= '0;
    end else if (!is_enc) begin
      time_r <= time_r + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn || !enable) begin
      enc_r <= '0;
    end else if (enc_hit) begin
      enc_r <= '0;
    end else if (is_enc && enc_rise) begin
      enc_r <= enc_r + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      tick <= 1'b0;
    end else begin
      tick <= enable && (time_hit || enc_hit);
    end
  end

endmodule : profile_pacer

// File: hdl/trigger_sync.sv
/*
  Two-flop synchroniser with rising-edge detection, one lane per input bit.
  Assumes a single clock and synchronous active-low reset.
*/
`timescale 1ns/10ps
module trigger_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] prev_r;

  generate
    if (WIDTH < 1) begin : g_bad
      $error("trigger_sync needs at least one lane");
    end
    for (genvar i = 0; i < WIDTH; i++) begin : g_lane
      always_ff @(posedge clock) begin
        if (!resetn) begin
          meta_r[i] <= 1'b0;
          sync_r[i] <= 1'b0;
          prev_r[i] <= 1'b0;
        end else begin
          meta_r[i] <= din[i];
          sync_r[i] <= meta_r[i];
          prev_r[i] <= sync_r[i];
        end
      end
      // edge taken from the settled samples only, never from meta_r
      assign rise[i] = sync_r[i] & ~prev_r[i];
      assign level[i] = sync_r[i];
    end
  endgenerate

endmodule : trigger_sync

// File: pkg/image_trigger_gate_defs.svh
/*
  Register offsets, field positions, reset values and timing counts for the
  image trigger gate. Assumes a 32-bit APB slave with word-aligned registers.
*/
`ifndef IMAGE_TRIGGER_GATE_DEFS_SVH
`define IMAGE_TRIGGER_GATE_DEFS_SVH

// register byte offsets
`define ITG_CTRL_OFS        8'h00
`define ITG_SERIES_LEN_OFS  8'h04
`define ITG_FREE_PERIOD_OFS 8'h08
`define ITG_PULSES_OFS      8'h0c
`define ITG_STATUS_OFS      8'h10
`define ITG_SERIES_CNT_OFS  8'h14

// control fields
`define ITG_CTRL_RUN_BIT    0
`define ITG_CTRL_GATE_BIT   1
`define ITG_CTRL_LEVEL_BIT  2
`define ITG_CTRL_ENC_BIT    3

// status fields
`define ITG_STAT_RUN_BIT    0
`define ITG_STAT_SERIES_BIT 1
`define ITG_STAT_TRIG_BIT   2
`define ITG_STAT_REFUSE_BIT 3
`define ITG_STAT_CNT_LSB    16

// reset values
`define ITG_SERIES_LEN_RST  16'h0064
`define ITG_PULSES_RST      16'h0001

// free-running profile period: 100 us at 100 MHz
`define ITG_CLK_MHZ         100
`define ITG_FREE_PERIOD_US  100
`define ITG_FREE_PERIOD_CYC (`ITG_FREE_PERIOD_US * `ITG_CLK_MHZ)

`endif

// File: pkg/image_trigger_gate_pkg.sv
/*
  Types shared by the image trigger gate modules.
  Assumes the constants header is compiled alongside.
*/
package image_trigger_gate_pkg;

  typedef enum logic [1:0] {
    st_stop,
    st_wait,
    st_series
  } gate_state_e;

  typedef enum logic {
    pace_free,
    pace_encoder
  } pace_src_e;

endpackage : image_trigger_gate_pkg

// File: verification/itg_checker_monitor.sv
/*
  Checker for the image trigger gate ports: apb handshake and profile pulses.
  Assumes the bench keeps free-running periods of two cycles or more.
*/
`timescale 1ns/10ps
module itg_checker (
  input wire logic clock,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic profile_trigger,
  input wire logic series_active,
  input wire logic series_done
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // six words from 0x00, anything else must answer with an error
  wire logic mapped = (paddr <= 8'h14) && (paddr[1:0] == 2'h0);

  ready_one_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready not one cycle into access");
  no_early_ready_a: assert property (psel && !penable |=> !pready)
    else $error("pready right after setup");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_unmapped_a: assert property (pready && !mapped |-> pslverr)
    else $error("unmapped address without pslverr");
  err_mapped_a: assert property (pready && mapped |-> !pslverr)
    else $error("pslverr on mapped address");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside answer");
  done_last_a: assert property (series_done |-> profile_trigger)
    else $error("series end without last profile");
  trig_series_a: assert property (profile_trigger |-> series_active || $past(series_active))
    else $error("profile outside a series");
  trig_single_a: assert property (profile_trigger |=> !profile_trigger)
    else $error("profile pulse longer than one cycle");
endmodule : itg_checker

bind image_trigger_gate itg_checker chk (
  .clock(clock),
  .resetn(resetn),
  .psel(psel),
  .penable(penable),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .profile_trigger(profile_trigger),
  .series_active(series_active),
  .series_done(series_done)
);

// File: verification/tb_top.sv
/*
  Self-checking bench for the image trigger gate: apb master, counting model
  of series and profiles, sensor partner. Assumes header and package compiled.
*/
`timescale 1ns/10ps
`include "image_trigger_gate_defs.svh"
module tb_top;
  localparam int LEN = 4;
  logic clock;
  logic resetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  wire logic [31:0] prdata;
  wire logic pready;
  wire logic pslverr;
  wire logic image_trigger;
  wire logic encoder_pulse;
  wire logic profile_trigger;
  wire logic series_active;
  wire logic series_done;
  int miscompares = 0;
  int n_checks = 0;
  int n_prof = 0;
  int n_done = 0;
  // profile count at the end of the previous series, for the per-series model
  int prof_base = 0;
  int exp_prof = 0;
  int exp_done = 0;
  int seed = 32'h875257df;
  int i;
  logic [31:0] rd;
  logic err;
  logic [31:0] rst_tab [7] = '{32'h0, 32'h64, 32'(`ITG_FREE_PERIOD_CYC), 32'h1, 32'h0,
    32'h0, 32'h0};

  image_trigger_gate uut (
    .clock(clock),
    .resetn(resetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .image_trigger(image_trigger),
    .encoder_pulse(encoder_pulse),
    .profile_trigger(profile_trigger),
    .series_active(series_active),
    .series_done(series_done)
  );

  trigger_sensor sensor (
    .clock(clock),
    .trig(image_trigger),
    .enc(encoder_pulse)
  );

  always #5 clock = ~clock;

  // every finished series must carry exactly the set number of profiles
  always @(posedge clock) begin
    if (profile_trigger === 1'b1) n_prof++;
    if (series_done === 1'b1) begin
      n_done++;
      check("series length", 32'(LEN), 32'(n_prof - prof_base));
      prof_base = n_prof;
    end
  end

  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      t++;
    end while (pready !== 1'b1 && t < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (t >= 20) check("pready", 32'h1, 32'h0);
  endtask : apb

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask : idle

  // bounded so a gate that never ends a series still reaches the verdict
  task automatic wait_done(input int target);
    int t;
    for (t = 0; t < 3000 && n_done < target; t++) @(posedge clock);
  endtask : wait_done

  task automatic model_cmp;
    check("profiles", exp_prof, n_prof);
    check("series", exp_done, n_done);
  endtask : model_cmp

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  initial begin
    clock = 1'b0;
    resetn <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0000_0000;
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    for (i = 0; i < 7; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      check("reset value", rst_tab[i], rd);
      check("slverr", 32'(i == 6), 32'(err));
    end
    apb(1'b1, 8'h08, 32'h3);
    apb(1'b1, 8'h04, 32'(LEN));
    apb(1'b1, 8'h00, 32'h3);
    sensor.set_trig(1'b1);
    idle(8);
    check("series active", 32'h1, 32'(series_active));
    sensor.set_trig(1'b0);
    idle(2);
    sensor.set_trig(1'b1);
    idle(80);
    exp_prof += LEN;
    exp_done++;
    model_cmp();
    apb(1'b1, 8'h04, 32'h9);
    apb(1'b0, 8'h04, 32'h0);
    check("locked length", 32'(LEN), rd);
    apb(1'b0, 8'h10, 32'h0);
    check("status", 32'hd, {28'h0, rd[3:0]});
    apb(1'b1, 8'h10, 32'h8);
    apb(1'b0, 8'h10, 32'h0);
    check("status", 32'h5, {28'h0, rd[3:0]});
    sensor.set_trig(1'b0);
    idle(4);
    sensor.set_trig(1'b1);
    wait_done(exp_done + 1);
    sensor.set_trig(1'b0);
    idle(20);
    exp_prof += LEN;
    exp_done++;
    model_cmp();
    apb(1'b1, 8'h00, 32'h2);
    apb(1'b1, 8'h00, 32'h6);
    sensor.set_trig(1'b1);
    idle(4);
    apb(1'b1, 8'h00, 32'h7);
    idle(60);
    model_cmp();
    check("series active", 32'h0, 32'(series_active));
    sensor.set_trig(1'b0);
    idle(4);
    sensor.set_trig(1'b1);
    wait_done(exp_done + 2);
    sensor.set_trig(1'b0);
    idle(40);
    exp_prof += 3 * LEN;
    exp_done += 3;
    model_cmp();
    apb(1'b1, 8'h00, 32'h6);
    // longer period so the stop lands before the next series' first profile
    apb(1'b1, 8'h08, 32'h8);
    apb(1'b1, 8'h00, 32'h1);
    wait_done(exp_done + 3);
    apb(1'b1, 8'h00, 32'h0);
    idle(20);
    exp_prof += 3 * LEN;
    exp_done += 3;
    model_cmp();
    apb(1'b0, 8'h14, 32'h0);
    check("series count", 32'(exp_done), rd);
    apb(1'b1, 8'h0c, 32'h3);
    apb(1'b1, 8'h00, 32'h8);
    apb(1'b1, 8'h00, 32'h9);
    idle(10);
    sensor.enc_pulses(3 * LEN, seed);
    idle(20);
    exp_prof += LEN;
    exp_done++;
    model_cmp();
    conclude();
  end

  initial begin
    repeat (50000) @(posedge clock);
    miscompares++;
    conclude();
  end
endmodule : tb_top

// File: verification/trigger_sensor.sv
/*
  Model of the external sensor side: image trigger switch and encoder.
  Assumes the caller sits in the clock domain of the gate.
*/
`timescale 1ns/10ps
module trigger_sensor (
  input wire logic clock,
  output logic trig,
  output logic enc
);
  initial begin
    trig = 1'b0;
    enc = 1'b0;
  end

  task automatic set_trig(input logic v);
    @(posedge clock);
    trig <= v;
  endtask : set_trig

  // random high and low times, never below two cycles so the sync sees each pulse
  task automatic enc_pulses(input int n, inout int seed);
    int k;
    for (k = 0; k < n; k++) begin
      @(posedge clock);
      enc <= 1'b1;
      repeat (($random(seed) & 3) + 2) @(posedge clock);
      enc <= 1'b0;
      repeat (($random(seed) & 3) + 2) @(posedge clock);
    end
  endtask : enc_pulses
endmodule : trigger_sensor
